// ===== hdl/tsrr_core.sv
`include "tsrr_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module tsrr_core (
    input  wire logic                 core_clk_i,
    input  wire logic                 rst_n_i,
    input  wire logic                 psel_i,
    input  wire logic                 penable_i,
    input  wire logic                 pwrite_i,
    input  wire logic [7:0]           paddr_i,
    input  wire logic [31:0]          pwdata_i,
    output logic                      pready_o,
    output logic [31:0]               prdata_o,
    output logic                      pslverr_o,
    input  wire logic                 cmd_valid_i,
    input  wire logic [2:0]           cmd_initiator_i,
    input  wire logic [7:0]           cmd_opcode_i,
    input  wire logic [7:0]           cmd_byte1_i,
    input  wire logic [7:0]           cmd_byte5_i,
    input  wire logic                 cmd_fail_i,
    output logic                      cmd_ready_o,
    output logic                      status_valid_o,
    output logic [7:0]                status_code_o,
    output logic [2:0]                status_initiator_o,
    input  wire logic                 bus_device_reset_i,
    input  wire logic                 scsi_bus_reset_i,
    input  wire logic                 at_physical_end_i,
    input  wire logic                 servo_fault_i,
    input  wire logic                 formatter_fault_i,
    input  wire logic                 splice_gap_missing_i,
    input  wire logic                 splice_overshoot_i,
    input  wire logic [23:0]          logical_tape_end_i,
    input  wire logic [23:0]          physical_position_i,
    input  wire logic                 write_buffer_dirty_i,
    input  wire logic                 flush_done_i,
    input  wire logic                 rewind_done_i,
    output logic                      flush_start_o,
    output logic                      rewind_start_o,
    output tsrr_pkg::tsrr_state_t     rewind_state_o,
    output logic [7:0]                sense_byte20_o,
    output logic [7:0]                sense_byte21_o,
    output logic [23:0]               remaining_tape_o,
    output logic [3:0]                sense_key_o,
    output logic [7:0]                sense_pending_o,
    output logic                      reserved_o,
    output logic [2:0]                reserve_owner_o
);
    import tsrr_pkg::*;

    function automatic logic [3:0] pick_key(input logic hw,
                                            input logic illegal);
        pick_key = hw ? `TSRR_KEY_HW :
                   illegal ? `TSRR_KEY_ILLEGAL : `TSRR_KEY_NONE;
    endfunction

    logic        bus_rst_meta_r;
    logic        bus_rst_r;
    logic        pready_r;
    logic [31:0] prdata_r;
    logic        pslverr_r;
    logic        ready_r;
    logic        status_valid_r;
    logic [7:0]  status_code_r;
    logic [2:0]  status_init_r;
    logic        flush_start_r;
    logic        rewind_start_r;
    tsrr_state_t state_r;
    tsrr_state_t state_nxt;
    logic        immed_r;
    logic [2:0]  rew_init_r;
    logic [7:0]  byte20_r;
    logic [7:0]  byte21_r;
    logic [23:0] remaining_r;
    logic [3:0]  key_r;
    logic [7:0]  pending_r;
    logic        reserved_r;
    logic [2:0]  owner_r;

    logic        take;
    logic        is_inq;
    logic        is_rs;
    logic        is_rew;
    logic        is_res;
    logic        is_rel;
    logic        conflict;
    logic        third_bad;
    logic        fault_any;
    logic        hw_check;
    logic        check;
    logic        clears_own;
    logic        any_reset;
    logic        sw_clear;
    logic        sw_release;
    logic        apb_wr;
    logic        apb_rd;

    // scsi bus reset arrives from the pins
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bus_rst_meta_r <= 1'b0;
            bus_rst_r      <= 1'b0;
        end else begin
            bus_rst_meta_r <= scsi_bus_reset_i;
            bus_rst_r      <= bus_rst_meta_r;
        end
    end

    assign any_reset  = bus_device_reset_i | bus_rst_r;
    assign take       = cmd_valid_i & ready_r;
    assign is_inq     = cmd_opcode_i == `TSRR_OP_INQUIRY;
    assign is_rs      = cmd_opcode_i == `TSRR_OP_REQ_SENSE;
    assign is_rew     = cmd_opcode_i == `TSRR_OP_REWIND;
    assign is_res     = cmd_opcode_i == `TSRR_OP_RESERVE;
    assign is_rel     = cmd_opcode_i == `TSRR_OP_RELEASE;
    assign conflict   = reserved_r & (cmd_initiator_i != owner_r) & !is_inq
                        & !(is_rs & !cmd_byte5_i[`TSRR_RC_BIT]);
    assign third_bad  = is_res & cmd_byte1_i[`TSRR_THIRD_BIT];
    assign fault_any  = byte20_r[`TSRR_B20_SERVO] | byte20_r[`TSRR_B20_FMT]
                        | byte21_r[`TSRR_B21_GAP] | byte21_r[`TSRR_B21_OVER];
    // a pending initiator's next unconflicted command other than inquiry or request sense clears, then runs on clean state
    assign clears_own = take & !conflict & !is_inq & !is_rs
                        & pending_r[cmd_initiator_i];
    assign hw_check   = fault_any & !is_inq & !is_rs
                        & !pending_r[cmd_initiator_i];
    assign check      = !conflict & (cmd_fail_i | third_bad | hw_check);

    // apb slave: answers in the second access cycle
    assign apb_wr     = psel_i & penable_i & pwrite_i & !pready_r;
    assign apb_rd     = psel_i & penable_i & !pwrite_i & !pready_r;
    assign sw_clear   = apb_wr & (paddr_i == `TSRR_REG_CTRL)
                        & pwdata_i[`TSRR_CTRL_CLR_SENSE];
    assign sw_release = apb_wr & (paddr_i == `TSRR_REG_CTRL)
                        & pwdata_i[`TSRR_CTRL_RELEASE];

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pready_r  <= 1'b0;
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else begin
            pready_r  <= psel_i & penable_i & !pready_r;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
            if (psel_i & penable_i & !pready_r) begin
                unique case (paddr_i)
                    `TSRR_REG_CTRL:   prdata_r <= 32'h0000_0000;
                    `TSRR_REG_STATUS: prdata_r <= {16'h0000, pending_r,
                                                   2'b00, state_r, owner_r,
                                                   reserved_r};
                    `TSRR_REG_SENSE:  prdata_r <= {12'h000, key_r,
                                                   byte20_r, byte21_r};
                    `TSRR_REG_REMAIN: prdata_r <= {8'h00, remaining_r};
                    default:          pslverr_r <= 1'b1;
                endcase
                if (!apb_rd)
                    prdata_r <= 32'h0000_0000;
            end
        end
    end

    // unit sense flags: hardware set wins over any clear
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            byte20_r <= 8'h00;
            byte21_r <= 8'h00;
        end else begin
            byte21_r[`TSRR_B21_PHYSICAL_TAPE_END_FLAG] <= at_physical_end_i;
            if (clears_own | any_reset | sw_clear) begin
                byte20_r[`TSRR_B20_SERVO] <= 1'b0;
                byte20_r[`TSRR_B20_FMT]   <= 1'b0;
                byte21_r[`TSRR_B21_GAP]   <= 1'b0;
                byte21_r[`TSRR_B21_OVER]  <= 1'b0;
            end
            if (servo_fault_i)
                byte20_r[`TSRR_B20_SERVO] <= 1'b1;
            if (formatter_fault_i)
                byte20_r[`TSRR_B20_FMT] <= 1'b1;
            if (splice_gap_missing_i)
                byte21_r[`TSRR_B21_GAP] <= 1'b1;
            if (splice_overshoot_i)
                byte21_r[`TSRR_B21_OVER] <= 1'b1;
        end
    end

    // position inputs may put the end one block past the written data
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            remaining_r <= 24'h00_0000;
        else if (logical_tape_end_i >= physical_position_i)
            remaining_r <= logical_tape_end_i - physical_position_i;
        else
            remaining_r <= 24'h00_0000;
    end

    // pending sense per initiator and the sense key
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pending_r <= 8'h00;
            key_r     <= `TSRR_KEY_NONE;
        end else begin
            if (any_reset | sw_clear) begin
                pending_r <= 8'h00;
                key_r     <= `TSRR_KEY_NONE;
            end else if (clears_own) begin
                pending_r[cmd_initiator_i] <= 1'b0;
            end
            if (take & check & !is_rs) begin
                pending_r[cmd_initiator_i] <= 1'b1;
                key_r <= pick_key(hw_check, cmd_fail_i | third_bad);
            end
        end
    end

    // reservation
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reserved_r <= 1'b0;
            owner_r    <= 3'h0;
        end else if (any_reset | sw_release) begin
            reserved_r <= 1'b0;
        end else if (take & !conflict & !check) begin
            if (is_res) begin
                reserved_r <= 1'b1;
                owner_r    <= cmd_initiator_i;
            end else if (is_rel) begin
                reserved_r <= 1'b0;
            end
        end
    end

    // rewind sequencer
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            TSRR_IDLE: begin
                if (take & is_rew & !conflict & !check)
                    state_nxt = write_buffer_dirty_i ? TSRR_FLUSH
                                                     : TSRR_WIND;
            end
            TSRR_FLUSH: begin
                if (flush_done_i)
                    state_nxt = TSRR_WIND;
            end
            TSRR_WIND: begin
                if (rewind_done_i)
                    state_nxt = TSRR_IDLE;
            end
            default: state_nxt = TSRR_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r        <= TSRR_IDLE;
            immed_r        <= 1'b0;
            rew_init_r     <= 3'h0;
            flush_start_r  <= 1'b0;
            rewind_start_r <= 1'b0;
        end else begin
            state_r        <= state_nxt;
            flush_start_r  <= (state_r == TSRR_IDLE)
                              & (state_nxt == TSRR_FLUSH);
            rewind_start_r <= (state_r != TSRR_WIND)
                              & (state_nxt == TSRR_WIND);
            if (take & is_rew) begin
                immed_r    <= cmd_byte1_i[`TSRR_IMMED_BIT];
                rew_init_r <= cmd_initiator_i;
            end
        end
    end

    // command status and readiness
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ready_r        <= 1'b0;
            status_valid_r <= 1'b0;
            status_code_r  <= `TSRR_ST_GOOD;
            status_init_r  <= 3'h0;
        end else begin
            ready_r        <= (state_nxt == TSRR_IDLE) & !take;
            status_valid_r <= 1'b0;
            if (take & (conflict | check | !is_rew)) begin
                status_valid_r <= 1'b1;
                status_init_r  <= cmd_initiator_i;
                status_code_r  <= conflict ? `TSRR_ST_CONFLICT
                                  : check ? `TSRR_ST_CHECK
                                  : `TSRR_ST_GOOD;
            end else if (immed_r & (state_r == TSRR_FLUSH)
                         & (state_nxt == TSRR_WIND)) begin
                status_valid_r <= 1'b1;
                status_init_r  <= rew_init_r;
                status_code_r  <= `TSRR_ST_GOOD;
            end else if (!immed_r & (state_r == TSRR_WIND)
                         & (state_nxt == TSRR_IDLE)) begin
                status_valid_r <= 1'b1;
                status_init_r  <= rew_init_r;
                status_code_r  <= `TSRR_ST_GOOD;
            end
            // a dirty buffer delays the immediate status to the wind start
            if (take & is_rew & !conflict & !check
                & cmd_byte1_i[`TSRR_IMMED_BIT] & !write_buffer_dirty_i) begin
                status_valid_r <= 1'b1;
                status_init_r  <= cmd_initiator_i;
                status_code_r  <= `TSRR_ST_GOOD;
            end
        end
    end

    assign pready_o           = pready_r;
    assign prdata_o           = prdata_r;
    assign pslverr_o          = pslverr_r;
    assign cmd_ready_o        = ready_r;
    assign status_valid_o     = status_valid_r;
    assign status_code_o      = status_code_r;
    assign status_initiator_o = status_init_r;
    assign flush_start_o      = flush_start_r;
    assign rewind_start_o     = rewind_start_r;
    assign rewind_state_o     = state_r;
    assign sense_byte20_o     = byte20_r;
    assign sense_byte21_o     = byte21_r;
    assign remaining_tape_o   = remaining_r;
    assign sense_key_o        = key_r;
    assign sense_pending_o    = pending_r;
    assign reserved_o         = reserved_r;
    assign reserve_owner_o    = owner_r;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    physical_tape_end_flag_track_a: assert property (
        ##1 byte21_r[`TSRR_B21_PHYSICAL_TAPE_END_FLAG] == $past(at_physical_end_i))
        else $error("end of tape flag does not track position");
    servo_set_a: assert property (
        servo_fault_i |=> byte20_r[`TSRR_B20_SERVO])
        else $error("servo fault not latched");
    fmt_set_a: assert property (
        formatter_fault_i |=> byte20_r[`TSRR_B20_FMT])
        else $error("formatter fault not latched");
    gap_set_a: assert property (
        splice_gap_missing_i |=> byte21_r[`TSRR_B21_GAP])
        else $error("splice gap flag not latched");
    over_set_a: assert property (
        splice_overshoot_i |=> byte21_r[`TSRR_B21_OVER])
        else $error("splice overshoot flag not latched");
    remain_calc_a: assert property (
        rst_n_i && logical_tape_end_i >= physical_position_i |=>
        remaining_r == $past(logical_tape_end_i) - $past(physical_position_i))
        else $error("remaining tape wrong");
    key_prio_a: assert property (
        take & hw_check & !conflict & !any_reset & !sw_clear & !is_rs
        |=> key_r == `TSRR_KEY_HW)
        else $error("hardware error not given priority");
    pend_hold_a: assert property (
        take & (is_inq | is_rs) & pending_r[cmd_initiator_i]
        & !any_reset & !sw_clear |=> pending_r[$past(cmd_initiator_i)])
        else $error("pending sense dropped by inquiry or sense");
    reset_clear_a: assert property (
        bus_device_reset_i & !take |=> pending_r == 8'h00 && !reserved_r)
        else $error("reset left pending sense or reservation");
    rs_keep_a: assert property (
        take & is_rs & !any_reset & !sw_clear
        |=> key_r == $past(key_r) && pending_r == $past(pending_r))
        else $error("failing request sense altered sense");
    reserve_take_a: assert property (
        take & is_res & !conflict & !check & !any_reset & !sw_release
        |=> reserved_r && owner_r == $past(cmd_initiator_i))
        else $error("reserve not taken");
    conflict_a: assert property (
        take & conflict |=> status_valid_r
        && status_code_r == `TSRR_ST_CONFLICT)
        else $error("reservation conflict not reported");
    third_party_a: assert property (
        take & third_bad & !conflict |=> status_valid_r
        && status_code_r == `TSRR_ST_CHECK && !$rose(reserved_r))
        else $error("third party reserve accepted");
    flush_first_a: assert property (
        flush_start_r |-> !rewind_start_r ##1 (state_r == TSRR_FLUSH
        && !rewind_start_r))
        else $error("rewind started before flush");
    immed_stat_a: assert property (
        rewind_start_r & immed_r |-> status_valid_r
        && status_code_r == `TSRR_ST_GOOD)
        else $error("immediate rewind status missing");
    late_stat_a: assert property (
        state_r == TSRR_WIND & rewind_done_i & !immed_r
        |=> status_valid_r && status_code_r == `TSRR_ST_GOOD)
        else $error("rewind completion status missing");

endmodule

`default_nettype wire

// ===== hdl/tsrr_defines.svh
`ifndef TSRR_DEFINES_SVH
`define TSRR_DEFINES_SVH

// command operation codes
`define TSRR_OP_REWIND      8'h01
`define TSRR_OP_REQ_SENSE   8'h03
`define TSRR_OP_INQUIRY     8'h12
`define TSRR_OP_RESERVE     8'h16
`define TSRR_OP_RELEASE     8'h17

// status codes returned to the initiator
`define TSRR_ST_GOOD        8'h00
`define TSRR_ST_CHECK       8'h02
`define TSRR_ST_CONFLICT    8'h18

// sense keys
`define TSRR_KEY_NONE       4'h0
`define TSRR_KEY_HW         4'h4
`define TSRR_KEY_ILLEGAL    4'h5

// cdb field positions
`define TSRR_IMMED_BIT      0
`define TSRR_THIRD_BIT      4
`define TSRR_RC_BIT         7

// unit sense bit positions
`define TSRR_B20_SERVO      1
`define TSRR_B20_FMT        0
`define TSRR_B21_PHYSICAL_TAPE_END_FLAG       2
`define TSRR_B21_GAP        1
`define TSRR_B21_OVER       0

// apb register byte offsets
`define TSRR_REG_CTRL       8'h00
`define TSRR_REG_STATUS     8'h04
`define TSRR_REG_SENSE      8'h08
`define TSRR_REG_REMAIN     8'h0c

// control register fields
`define TSRR_CTRL_CLR_SENSE 0
`define TSRR_CTRL_RELEASE   1

`endif

// ===== hdl/tsrr_pkg.sv
package tsrr_pkg;

    typedef enum logic [1:0] {
        TSRR_IDLE  = 2'b00,
        TSRR_FLUSH = 2'b01,
        TSRR_WIND  = 2'b11
    } tsrr_state_t;

endpackage

// ===== verification/tsrr_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module tsrr_host_model (
    input  wire logic       core_clk_i,
    input  wire logic       cmd_ready_i,
    output logic            cmd_valid_o,
    output logic [2:0]      cmd_initiator_o,
    output logic [7:0]      cmd_opcode_o,
    output logic [7:0]      cmd_byte1_o,
    output logic [7:0]      cmd_byte5_o,
    output logic            cmd_fail_o
);
    initial begin
        cmd_valid_o = 1'b0;
        cmd_initiator_o = 3'h0;
        cmd_opcode_o = 8'h00;
        cmd_byte1_o = 8'h00;
        cmd_byte5_o = 8'h00;
        cmd_fail_o = 1'b0;
    end

    // a retry after check is this task called again with the same fields
    task automatic issue(input logic [2:0] id, input logic [7:0] op,
                         input logic [7:0] b1, input logic rc,
                         input logic fail, input int slow);
        int n;
        repeat (slow) @(posedge core_clk_i);
        @(posedge core_clk_i);
        cmd_valid_o <= 1'b1;
        cmd_initiator_o <= id;
        cmd_opcode_o <= op;
        cmd_byte1_o <= b1;
        cmd_byte5_o <= {rc, 7'h00};
        cmd_fail_o <= fail;
        for (n = 0; n < 100; n++) begin
            @(posedge core_clk_i);
            if (cmd_ready_i) break;
        end
        // released lines must not keep showing the old command
        cmd_valid_o <= 1'b0;
        cmd_initiator_o <= ~id;
        cmd_opcode_o <= ~op;
        cmd_byte1_o <= ~b1;
        cmd_byte5_o <= {~rc, 7'h7f};
        cmd_fail_o <= ~fail;
    endtask
endmodule

`default_nettype wire

// ===== verification/tb_tape_sense_reserve_rewind.sv
`timescale 1ns/1ps
`default_nettype none
`include "tsrr_defines.svh"

module tb_tape_sense_reserve_rewind;
    import tsrr_pkg::*;
    logic        core_clk_i = 1'b0, rst_n_i = 1'b0;
    logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [7:0]  paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0, prdata_o;
    logic        pready_o, pslverr_o, cmd_valid_i, cmd_fail_i, cmd_ready_o;
    logic [2:0]  cmd_initiator_i, status_initiator_o, reserve_owner_o;
    logic [7:0]  cmd_opcode_i, cmd_byte1_i, cmd_byte5_i, status_code_o;
    logic        status_valid_o, bus_device_reset_i = 1'b0;
    logic        scsi_bus_reset_i = 1'b0, at_physical_end_i = 1'b0;
    logic        servo_fault_i = 1'b0, formatter_fault_i = 1'b0;
    logic        splice_gap_missing_i = 1'b0, splice_overshoot_i = 1'b0;
    logic [23:0] logical_tape_end_i = 24'h001000, remaining_tape_o;
    logic [23:0] physical_position_i = 24'h000400;
    logic        write_buffer_dirty_i = 1'b0, flush_done_i = 1'b0;
    logic        rewind_done_i = 1'b0, flush_start_o, rewind_start_o;
    logic        reserved_o;
    tsrr_state_t rewind_state_o;
    logic [7:0]  sense_byte20_o, sense_byte21_o, sense_pending_o;
    logic [3:0]  sense_key_o;
    int          miscompares = 0, checks_done = 0;

    tsrr_core u_dut (
        .core_clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
        .pwdata_i, .pready_o, .prdata_o, .pslverr_o, .cmd_valid_i,
        .cmd_initiator_i, .cmd_opcode_i, .cmd_byte1_i, .cmd_byte5_i,
        .cmd_fail_i, .cmd_ready_o, .status_valid_o, .status_code_o,
        .status_initiator_o, .bus_device_reset_i, .scsi_bus_reset_i,
        .at_physical_end_i, .servo_fault_i, .formatter_fault_i,
        .splice_gap_missing_i, .splice_overshoot_i, .logical_tape_end_i,
        .physical_position_i, .write_buffer_dirty_i, .flush_done_i,
        .rewind_done_i, .flush_start_o, .rewind_start_o, .rewind_state_o,
        .sense_byte20_o, .sense_byte21_o, .remaining_tape_o, .sense_key_o,
        .sense_pending_o, .reserved_o, .reserve_owner_o
    );

    tsrr_host_model u_host (
        .core_clk_i, .cmd_ready_i(cmd_ready_o), .cmd_valid_o(cmd_valid_i),
        .cmd_initiator_o(cmd_initiator_i), .cmd_opcode_o(cmd_opcode_i),
        .cmd_byte1_o(cmd_byte1_i), .cmd_byte5_o(cmd_byte5_i),
        .cmd_fail_o(cmd_fail_i)
    );

    always #12.5 core_clk_i = ~core_clk_i;

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        int n;
        @(posedge core_clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge core_clk_i);
        penable_i <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge core_clk_i);
            if (pready_o === 1'b1) break;
        end
        q = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        if (n == 20) begin
            miscompares++;
            report_and_stop();
        end
    endtask

    task automatic wstat(input logic [2:0] id, input logic [7:0] code);
        int n;
        #1;
        for (n = 0; n < 200 && status_valid_o !== 1'b1; n++) begin
            @(posedge core_clk_i);
            #1;
        end
        chk(status_valid_o, 1'b1);
        if (status_valid_o !== 1'b1) report_and_stop();
        chk(status_code_o, code);
        chk(status_initiator_o, id);
    endtask

    task automatic cmd(input logic [2:0] id, input logic [7:0] op, b1,
                       input logic rc, fail, input logic [7:0] code);
        u_host.issue(id, op, b1, rc, fail, 0);
        wstat(id, code);
    endtask

    task automatic bus_reset();
        @(posedge core_clk_i);
        scsi_bus_reset_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        scsi_bus_reset_i <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        #1;
    endtask

    task automatic pulse(input logic flush);
        @(posedge core_clk_i);
        flush_done_i <= flush;
        rewind_done_i <= ~flush;
        write_buffer_dirty_i <= 1'b0;
        @(posedge core_clk_i);
        flush_done_i <= 1'b0;
        rewind_done_i <= 1'b0;
    endtask

    task automatic t_regs();
        logic [31:0] q;
        logic        e;
        apb(1'b0, `TSRR_REG_STATUS, 32'h0, q, e);
        chk(q, 32'h0);
        apb(1'b0, 8'h10, 32'h0, q, e);
        chk(e, 1'b1);
        chk(q, 32'h0);
        chk(remaining_tape_o, 24'h000c00);
        apb(1'b0, `TSRR_REG_REMAIN, 32'h0, q, e);
        chk(q, 32'h0000_0c00);
        $display("registers done");
    endtask

    task automatic t_sense();
        logic [31:0] q;
        logic        e;
        @(posedge core_clk_i);
        at_physical_end_i <= 1'b1;
        apb(1'b0, `TSRR_REG_SENSE, 32'h0, q, e);
        chk(q, 32'h0000_0004);
        @(posedge core_clk_i);
        at_physical_end_i <= 1'b0;
        {servo_fault_i, formatter_fault_i} <= 2'b11;
        {splice_gap_missing_i, splice_overshoot_i} <= 2'b11;
        @(posedge core_clk_i);
        {servo_fault_i, formatter_fault_i} <= 2'b00;
        {splice_gap_missing_i, splice_overshoot_i} <= 2'b00;
        apb(1'b0, `TSRR_REG_SENSE, 32'h0, q, e);
        chk(q, 32'h0000_0303);
        cmd(3'h1, `TSRR_OP_RELEASE, 8'h00, 1'b0, 1'b1, `TSRR_ST_CHECK);
        chk(sense_key_o, `TSRR_KEY_HW);
        cmd(3'h1, `TSRR_OP_REQ_SENSE, 8'h00, 1'b0, 1'b1, `TSRR_ST_CHECK);
        chk({sense_key_o, sense_byte20_o}, 12'h403);
        cmd(3'h1, `TSRR_OP_REQ_SENSE, 8'h00, 1'b0, 1'b0, `TSRR_ST_GOOD);
        cmd(3'h1, `TSRR_OP_INQUIRY, 8'h00, 1'b0, 1'b0, `TSRR_ST_GOOD);
        chk(sense_pending_o, 8'h02);
        cmd(3'h1, `TSRR_OP_RELEASE, 8'h00, 1'b0, 1'b0, `TSRR_ST_GOOD);
        chk({sense_pending_o, sense_byte20_o}, 16'h0000);
        $display("sense done");
    endtask

    task automatic t_resets();
        logic [31:0] q;
        logic        e;
        cmd(3'h2, `TSRR_OP_RELEASE, 8'h00, 1'b0, 1'b1, `TSRR_ST_CHECK);
        chk({sense_key_o, sense_pending_o}, 12'h504);
        @(posedge core_clk_i);
        bus_device_reset_i <= 1'b1;
        @(posedge core_clk_i);
        bus_device_reset_i <= 1'b0;
        @(posedge core_clk_i);
        #1;
        chk(sense_pending_o, 8'h00);
        cmd(3'h2, `TSRR_OP_RELEASE, 8'h00, 1'b0, 1'b1, `TSRR_ST_CHECK);
        bus_reset();
        chk(sense_pending_o, 8'h00);
        cmd(3'h2, `TSRR_OP_RELEASE, 8'h00, 1'b0, 1'b1, `TSRR_ST_CHECK);
        apb(1'b1, `TSRR_REG_CTRL, 32'h1, q, e);
        chk(sense_pending_o, 8'h00);
        $display("resets done");
    endtask

    task automatic t_reserve();
        logic [31:0] q;
        logic        e;
        cmd(3'h3, `TSRR_OP_RESERVE, 8'h00, 1'b0, 1'b0, `TSRR_ST_GOOD);
        chk({reserved_o, reserve_owner_o}, 4'hb);
        cmd(3'h4, `TSRR_OP_REWIND, 8'h00, 1'b0, 1'b0, `TSRR_ST_CONFLICT);
        cmd(3'h4, `TSRR_OP_REQ_SENSE, 8'h00, 1'b1, 1'b0, 8'h18);
        cmd(3'h4, `TSRR_OP_REQ_SENSE, 8'h00, 1'b0, 1'b0, 8'h00);
        cmd(3'h4, `TSRR_OP_INQUIRY, 8'h00, 1'b0, 1'b0, 8'h00);
        cmd(3'h4, `TSRR_OP_RELEASE, 8'h00, 1'b0, 1'b0, 8'h18);
        chk(reserved_o, 1'b1);
        cmd(3'h3, `TSRR_OP_RESERVE, 8'h10, 1'b0, 1'b0, 8'h02);
        cmd(3'h3, `TSRR_OP_RELEASE, 8'h00, 1'b0, 1'b0, `TSRR_ST_GOOD);
        chk(reserved_o, 1'b0);
        cmd(3'h2, `TSRR_OP_RESERVE, 8'h00, 1'b0, 1'b0, `TSRR_ST_GOOD);
        bus_reset();
        chk(reserved_o, 1'b0);
        cmd(3'h5, `TSRR_OP_RESERVE, 8'h00, 1'b0, 1'b0, `TSRR_ST_GOOD);
        apb(1'b1, `TSRR_REG_CTRL, 32'h2, q, e);
        @(posedge core_clk_i);
        #1;
        chk(reserved_o, 1'b0);
        $display("reserve done");
    endtask

    task automatic t_rewind();
        int n;
        u_host.issue(3'h0, `TSRR_OP_REWIND, 8'h01, 1'b0, 1'b0, 3);
        #1;
        chk({status_valid_o, rewind_start_o}, 2'b11);
        chk(rewind_state_o, TSRR_WIND);
        pulse(1'b0);
        @(posedge core_clk_i);
        write_buffer_dirty_i <= 1'b1;
        u_host.issue(3'h0, `TSRR_OP_REWIND, 8'h00, 1'b0, 1'b0, 0);
        #1;
        chk(flush_start_o, 1'b1);
        repeat (4) @(posedge core_clk_i);
        #1;
        chk(rewind_state_o, TSRR_FLUSH);
        pulse(1'b1);
        #1;
        for (n = 0; n < 20 && rewind_start_o !== 1'b1; n++) begin
            @(posedge core_clk_i);
            #1;
        end
        chk({rewind_start_o, status_valid_o}, 2'b10);
        pulse(1'b0);
        wstat(3'h0, `TSRR_ST_GOOD);
        $display("rewind done");
    endtask

    initial begin
        repeat (4) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        t_regs();
        t_sense();
        t_resets();
        t_reserve();
        t_rewind();
        report_and_stop();
    end
endmodule

`default_nettype wire
